// File: rtl/motor_seq_pkg.sv
package motor_seq_pkg;

   // Register byte addresses
   localparam logic [7:0] CONFIG_ADDR = 8'h00;
   localparam logic [7:0] LOCK_LEVEL_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam logic [7:0] LIMITS_ADDR = 8'h0C;

   // Configuration field positions
   localparam int CFG_SOFT_STOP_BIT = 3;
   localparam int CFG_CURRENT_START_BIT = 2;
   localparam int CFG_SENSOR_CAL_BIT = 1;
   localparam int CFG_AUTO_RESTART_BIT = 0;
   localparam int CFG_W = 4;

   // Status field positions
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_CLOSED_LOOP_BIT = 4;
   localparam int STAT_LOCK_FAULT_BIT = 5;
   localparam int STAT_COUNT_LSB = 8;

   // Reset values
   localparam logic [CFG_W-1:0] CONFIG_RESET = 4'h0;
   localparam logic [15:0] LOCK_LEVEL_RESET = 16'h7000;

   // Timing: hold times in ns, cycle counts derived at 125 MHz
   localparam int CLK_PERIOD_NS = 8;
   localparam int SENSOR_RESET_NS = 1000;
   localparam int RESTART_HOLD_NS = 1000;
   localparam int SENSOR_RESET_CYCLES = (SENSOR_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RESTART_HOLD_CYCLES = (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CNT_W = 8;
   localparam int LOCK_PERIODS = 100;

   // AXI response codes
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SENSOR_CAL,
      ST_ADC_CAL,
      ST_RUN,
      ST_RESTART,
      ST_STOP,
      ST_FAULT
   } seq_state_e;

endpackage

// File: rtl/lock_check_if.sv
`timescale 1ns/1ps
interface lock_check_if #(
   parameter int W = 16
);
   logic enable;
   logic period_done;
   logic signed [W-1:0] q_voltage;
   logic [W-1:0] level;
   logic lock;

   modport seq (output enable, output period_done, output q_voltage, output level, input lock);
   modport det (input enable, input period_done, input q_voltage, input level, output lock);
endinterface

// File: rtl/rise_detect.sv
`timescale 1ns/1ps
module rise_detect #(
   parameter int N = 2
) (
   input wire logic core_clk_i,   // System clock
   input wire logic nrst_i,       // Async reset, active low
   input wire logic [N-1:0] sig_i, // Same-clock levels
   output logic [N-1:0] rise_o    // One-cycle rise pulses
);
   logic [N-1:0] prev_q;

   for (genvar i = 0; i < N; i++) begin : g_bit
      always_ff @(posedge core_clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            prev_q[i] <= 1'b0;
         end else begin
            prev_q[i] <= sig_i[i];
         end
      end
      assign rise_o[i] = sig_i[i] & ~prev_q[i];
   end
endmodule

// File: rtl/rotor_lock_detect.sv
`timescale 1ns/1ps
module rotor_lock_detect
   import motor_seq_pkg::*;
#(
   parameter int W = 16,
   parameter int PERIODS = LOCK_PERIODS
) (
   input wire logic core_clk_i, // System clock
   input wire logic nrst_i,     // Async reset, active low
   lock_check_if.det chk        // Lock check channel
);
   localparam int CW = $clog2(PERIODS + 1);
   localparam logic [CW-1:0] LAST = CW'(PERIODS - 1);
   logic [CW-1:0] cnt_q;
   logic lock_q;

   function automatic logic [W-1:0] magnitude(input logic signed [W-1:0] v);
      magnitude = v[W-1] ? W'(-v) : W'(v);
   endfunction

   // Saturated |vq| held for many loop periods means the rotor does not follow
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt_q <= '0;
         lock_q <= 1'b0;
      end else begin
         lock_q <= 1'b0;
         if (!chk.enable) begin
            cnt_q <= '0;
         end else if (chk.period_done) begin
            if (magnitude(chk.q_voltage) >= chk.level) begin
               if (cnt_q == LAST) begin
                  lock_q <= 1'b1;
                  cnt_q <= '0;
               end else begin
                  cnt_q <= cnt_q + CW'(1);
               end
            end else begin
               cnt_q <= '0;
            end
         end
      end
   end

   assign chk.lock = lock_q;
endmodule

// File: rtl/motor_control_sequencer.sv
// Overview of operation
// - Start and stop requests drive sequences
// - Closed-loop flag while reference meets threshold
// - Watch q-axis voltage for rotor lock
// - Rotor lock restarts motor from zero
// - Count restarts; fault when limit reached
// - Issue ADC start-conversion rising-edge pulse
// - Enable current loops only when running
// - Drive PWM enable output
// - PWM enable follows operating state
// - Halted level while motor not running
// - Sensor reset output starts sensor calibration
// - Fault input forces fault state, motor stopped
// - Fault release rise, fault low, goes idle
// - Start on rising edge of request
// - Decode soft stop, startup, calibration, auto restart
`timescale 1ns/1ps
module motor_control_sequencer
   import motor_seq_pkg::*;
#(
   parameter int W = 16,
   parameter int RESTART_W = 8
) (
   input wire logic core_clk_i, // System clock, 125 MHz
   input wire logic nrst_i, // Async reset, active low
   input wire logic fault_i, // Fault level
   input wire logic start_motor_i, // Start request, rise acts
   input wire logic stop_motor_i, // Stop request level
   input wire logic fault_release_i, // Fault clear, rise acts
   input wire logic calib_done_i, // ADC offset ready level
   input wire logic pwm_midmatch_i, // PWM mid-period pulse
   input wire logic foc_done_i, // Loop computation done pulse
   input wire logic signed [W-1:0] speed_ref_i, // Speed reference
   input wire logic signed [W-1:0] closed_loop_threshold_speed_i, // Closed-loop threshold
   input wire logic signed [W-1:0] q_axis_voltage_i, // Current PI q output
   input wire logic [RESTART_W-1:0] restart_limit_i, // Max auto restarts
   output logic adc_start_o, // ADC start pulse
   output logic closed_loop_active_o, // Closed-loop status
   output logic current_loop_enable_o, // Current PI enable
   output logic pwm_enable_o, // PWM block enable
   output logic motor_halted_o, // Motor not running
   output logic sensor_reset_o, // Sensor reset/calibrate
   output logic soft_stop_o, // Soft stop to rate limiter
   output logic current_startup_o, // Startup mode: 1 C/f, 0 V/f
   input wire logic [7:0] s_axi_awaddr, // Write address
   input wire logic s_axi_awvalid, // Write address valid
   output logic s_axi_awready, // Write address ready
   input wire logic [31:0] s_axi_wdata, // Write data
   input wire logic [3:0] s_axi_wstrb, // Write strobes
   input wire logic s_axi_wvalid, // Write data valid
   output logic s_axi_wready, // Write data ready
   output logic [1:0] s_axi_bresp, // Write response
   output logic s_axi_bvalid, // Write response valid
   input wire logic s_axi_bready, // Write response ready
   input wire logic [7:0] s_axi_araddr, // Read address
   input wire logic s_axi_arvalid, // Read address valid
   output logic s_axi_arready, // Read address ready
   output logic [31:0] s_axi_rdata, // Read data
   output logic [1:0] s_axi_rresp, // Read response
   output logic s_axi_rvalid, // Read data valid
   input wire logic s_axi_rready // Read data ready
);

   seq_state_e state_q, state_d;
   logic [CFG_W-1:0] config_q;
   logic [W-1:0] lock_level_q;
   logic [RESTART_W-1:0] restart_cnt_q;
   logic [HOLD_CNT_W-1:0] hold_cnt_q;
   logic lock_fault_q;
   logic start_rise, release_rise;
   logic [1:0] rises;
   logic hold_done;
   logic running_d;

   logic aw_full_q, w_full_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic write_go;

   lock_check_if #(.W(W)) chk ();

   rise_detect #(.N(2)) u_rise (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .sig_i({fault_release_i, start_motor_i}),
      .rise_o(rises)
   );
   assign start_rise = rises[0];
   assign release_rise = rises[1];

   rotor_lock_detect #(.W(W)) u_lock (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .chk(chk)
   );
   assign chk.enable = (state_q == ST_RUN);
   assign chk.period_done = foc_done_i;
   assign chk.q_voltage = q_axis_voltage_i;
   assign chk.level = lock_level_q;

   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
      for (int b = 0; b < 4; b++) begin
         old[8*b +: 8] = strb[b] ? data[8*b +: 8] : old[8*b +: 8];
      end
      merge_strb = old;
   endfunction

   function automatic logic addr_known(input logic [7:0] a);
      addr_known = (a == CONFIG_ADDR) || (a == LOCK_LEVEL_ADDR) || (a == STATUS_ADDR) ||
                   (a == LIMITS_ADDR);
   endfunction

   assign hold_done = (hold_cnt_q == '0);

   // Sequencing state machine
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE: begin
            if (start_rise && !stop_motor_i) begin
               state_d = config_q[CFG_SENSOR_CAL_BIT] ? ST_SENSOR_CAL : ST_ADC_CAL;
            end
         end
         ST_SENSOR_CAL: begin
            if (hold_done) begin
               state_d = ST_ADC_CAL;
            end
         end
         ST_ADC_CAL: begin
            if (calib_done_i) begin
               state_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (chk.lock) begin
               if (config_q[CFG_AUTO_RESTART_BIT] && restart_cnt_q < restart_limit_i) begin
                  state_d = ST_RESTART;
               end else begin
                  state_d = ST_FAULT;
               end
            end
         end
         ST_RESTART: begin
            if (hold_done) begin
               state_d = ST_RUN;
            end
         end
         ST_STOP: begin
            // Soft stop waits for the rate limiter to bring the reference to zero
            if (!config_q[CFG_SOFT_STOP_BIT] || speed_ref_i == '0) begin
               state_d = ST_IDLE;
            end
         end
         ST_FAULT: begin
            if (release_rise && !fault_i) begin
               state_d = ST_IDLE;
            end
         end
      endcase
      if (stop_motor_i && state_q inside {ST_SENSOR_CAL, ST_ADC_CAL, ST_RUN, ST_RESTART}) begin
         state_d = ST_STOP;
      end
      if (fault_i) begin
         state_d = ST_FAULT;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Hold timer for sensor reset and restart pause
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         hold_cnt_q <= '0;
      end else if (state_d != state_q) begin
         if (state_d == ST_SENSOR_CAL) begin
            hold_cnt_q <= HOLD_CNT_W'(SENSOR_RESET_CYCLES - 1);
         end else if (state_d == ST_RESTART) begin
            hold_cnt_q <= HOLD_CNT_W'(RESTART_HOLD_CYCLES - 1);
         end else begin
            hold_cnt_q <= '0;
         end
      end else if (!hold_done) begin
         hold_cnt_q <= hold_cnt_q - HOLD_CNT_W'(1);
      end
   end

   // Restart count lives across restarts; a fresh start or a fault release clears it
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         restart_cnt_q <= '0;
         lock_fault_q <= 1'b0;
      end else begin
         if (state_q == ST_RUN && state_d == ST_RESTART) begin
            restart_cnt_q <= restart_cnt_q + RESTART_W'(1);
         end else if ((state_q == ST_IDLE && state_d != ST_IDLE) ||
                      (state_q == ST_FAULT && state_d == ST_IDLE)) begin
            restart_cnt_q <= '0;
         end
         if (state_q == ST_RUN && chk.lock && state_d == ST_FAULT) begin
            lock_fault_q <= 1'b1;
         end else if (state_q == ST_FAULT && state_d == ST_IDLE) begin
            lock_fault_q <= 1'b0;
         end
      end
   end

   // Motor counts as running while PWM drives it, including a soft stop ramp
   assign running_d = (state_d == ST_RUN) ||
                      (state_d == ST_STOP && config_q[CFG_SOFT_STOP_BIT]);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pwm_enable_o <= 1'b0;
         current_loop_enable_o <= 1'b0;
         motor_halted_o <= 1'b1;
         sensor_reset_o <= 1'b0;
         soft_stop_o <= 1'b0;
      end else begin
         pwm_enable_o <= running_d;
         current_loop_enable_o <= running_d;
         motor_halted_o <= !running_d;
         sensor_reset_o <= (state_d == ST_SENSOR_CAL);
         soft_stop_o <= (state_d == ST_STOP) && config_q[CFG_SOFT_STOP_BIT];
      end
   end

   // ADC is triggered during offset calibration, while running and in the stop state
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         adc_start_o <= 1'b0;
      end else begin
         adc_start_o <= pwm_midmatch_i && (state_q inside {ST_ADC_CAL, ST_RUN, ST_STOP});
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         closed_loop_active_o <= 1'b0;
         current_startup_o <= 1'b0;
      end else begin
         closed_loop_active_o <= (speed_ref_i >= closed_loop_threshold_speed_i);
         current_startup_o <= config_q[CFG_CURRENT_START_BIT];
      end
   end

   // AXI4-Lite write: address and data accepted in either order
   assign write_go = aw_full_q && w_full_q && !s_axi_bvalid;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_full_q <= 1'b0;
         waddr_q <= '0;
         s_axi_awready <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full_q <= 1'b1;
         waddr_q <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end else begin
         if (write_go) begin
            aw_full_q <= 1'b0;
         end
         s_axi_awready <= !aw_full_q && !s_axi_bvalid;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         w_full_q <= 1'b0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_wready <= 1'b0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full_q <= 1'b1;
         wdata_q <= s_axi_wdata;
         wstrb_q <= s_axi_wstrb;
         s_axi_wready <= 1'b0;
      end else begin
         if (write_go) begin
            w_full_q <= 1'b0;
         end
         s_axi_wready <= !w_full_q && !s_axi_bvalid;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (write_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= addr_known(waddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // Status and limits are read-only; writes to them are accepted and dropped
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         config_q <= CONFIG_RESET;
         lock_level_q <= LOCK_LEVEL_RESET;
      end else if (write_go) begin
         if (waddr_q == CONFIG_ADDR) begin
            config_q <= CFG_W'(merge_strb(32'(config_q), wdata_q, wstrb_q));
         end
         if (waddr_q == LOCK_LEVEL_ADDR) begin
            lock_level_q <= W'(merge_strb(32'(lock_level_q), wdata_q, wstrb_q));
         end
      end
   end

   // AXI4-Lite read
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= addr_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         s_axi_rdata <= '0;
         unique case (s_axi_araddr)
            CONFIG_ADDR: begin
               s_axi_rdata <= 32'(config_q);
            end
            LOCK_LEVEL_ADDR: begin
               s_axi_rdata <= 32'(lock_level_q);
            end
            STATUS_ADDR: begin
               s_axi_rdata[STAT_STATE_LSB +: 3] <= state_q;
               s_axi_rdata[STAT_CLOSED_LOOP_BIT] <= closed_loop_active_o;
               s_axi_rdata[STAT_LOCK_FAULT_BIT] <= lock_fault_q;
               s_axi_rdata[STAT_COUNT_LSB +: RESTART_W] <= restart_cnt_q;
            end
            LIMITS_ADDR: begin
               s_axi_rdata <= 32'(restart_limit_i);
            end
            default: begin
               s_axi_rdata <= '0;
            end
         endcase
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// File: tb/motor_control_sequencer_props.sv
`timescale 1ns/1ps
module motor_control_sequencer_props
   import motor_seq_pkg::*;
#(
   parameter int W = 16
) (
   input wire logic core_clk_i, // Clock
   input wire logic nrst_i, // Reset
   input wire logic fault_i, // Fault
   input wire logic start_motor_i, // Start
   input wire logic stop_motor_i, // Stop
   input wire logic pwm_midmatch_i, // Mid pulse
   input wire logic signed [W-1:0] speed_ref_i, // Reference
   input wire logic signed [W-1:0] closed_loop_threshold_speed_i, // Threshold
   input wire logic adc_start_o, // ADC start
   input wire logic closed_loop_active_o, // Closed loop
   input wire logic current_loop_enable_o, // PI enable
   input wire logic pwm_enable_o, // PWM enable
   input wire logic motor_halted_o, // Halted
   input wire logic sensor_reset_o, // Sensor reset
   input wire logic soft_stop_o // Soft stop
);
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!nrst_i);
   logic [7:0] cal_len_q;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cal_len_q <= 8'h00;
      end else begin
         cal_len_q <= sensor_reset_o ? cal_len_q + 8'h01 : 8'h00;
      end
   end
   a_halt_mirror: assert property (motor_halted_o == !pwm_enable_o)
      else $error("halted is not the inverse of pwm enable");
   a_loop_pwm: assert property (current_loop_enable_o == pwm_enable_o)
      else $error("current loop enable differs from pwm enable");
   a_closed_loop: assert property (nrst_i |=> closed_loop_active_o ==
      ($signed($past(speed_ref_i)) >= $signed($past(closed_loop_threshold_speed_i))))
      else $error("closed loop flag wrong");
   a_adc_cause: assert property (adc_start_o |-> $past(pwm_midmatch_i))
      else $error("adc start without mid pulse");
   a_adc_single: assert property (adc_start_o |=> !adc_start_o)
      else $error("adc start longer than one cycle");
   a_fault_stops: assert property (fault_i |=> !pwm_enable_o && motor_halted_o)
      else $error("motor running after fault");
   a_sensor_len: assert property ($fell(sensor_reset_o) && !fault_i && !stop_motor_i |->
      cal_len_q == SENSOR_RESET_CYCLES)
      else $error("sensor reset length wrong");
   a_start_rise: assert property ($rose(sensor_reset_o) |-> $past(start_motor_i) && !$past(start_motor_i, 2))
      else $error("sequence started without start rise");
   a_stop_halts: assert property (stop_motor_i |=> soft_stop_o || !pwm_enable_o)
      else $error("motor still driven after stop");
   a_soft_ramp: assert property (soft_stop_o |-> pwm_enable_o)
      else $error("soft stop without drive");
   c_sensor_done: cover property ($fell(sensor_reset_o));
   c_soft: cover property ($rose(soft_stop_o));
   c_fault: cover property (fault_i ##1 motor_halted_o);
endmodule

bind motor_control_sequencer motor_control_sequencer_props #(.W(W)) u_props (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .fault_i(fault_i), .start_motor_i(start_motor_i),
   .stop_motor_i(stop_motor_i), .pwm_midmatch_i(pwm_midmatch_i), .speed_ref_i(speed_ref_i),
   .closed_loop_threshold_speed_i(closed_loop_threshold_speed_i), .adc_start_o(adc_start_o),
   .closed_loop_active_o(closed_loop_active_o), .current_loop_enable_o(current_loop_enable_o),
   .pwm_enable_o(pwm_enable_o), .motor_halted_o(motor_halted_o), .sensor_reset_o(sensor_reset_o),
   .soft_stop_o(soft_stop_o)
);

// File: tb/motor_far_side_model.sv
`timescale 1ns/1ps
module motor_far_side_model #(
   parameter int PERIOD = 16
) (
   input wire logic core_clk_i, // Clock
   input wire logic nrst_i, // Reset
   input wire logic adc_start_i, // Conversion start
   input wire logic loop_enable_i, // Loop running
   input wire logic sensor_reset_i, // Sensor recalibration
   input wire logic [3:0] calib_samples_i, // Samples before offset ready
   output logic midmatch_o, // Mid-period pulse
   output logic foc_done_o, // Loop done pulse
   output logic calib_done_o // Offset ready level
);
   logic [7:0] tick_q;
   logic [3:0] samp_q;
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tick_q <= 8'h00;
         midmatch_o <= 1'b0;
      end else begin
         tick_q <= (tick_q == 8'(PERIOD - 1)) ? 8'h00 : tick_q + 8'h01;
         midmatch_o <= (tick_q == 8'(PERIOD - 1));
      end
   end
   // Sample count clears while the loop runs or the sensor resets, so a level left from a run never skips calibration
   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         samp_q <= 4'h0;
         foc_done_o <= 1'b0;
         calib_done_o <= 1'b0;
      end else begin
         foc_done_o <= adc_start_i && loop_enable_i;
         if (sensor_reset_i || loop_enable_i) begin
            samp_q <= 4'h0;
         end else if (adc_start_i && samp_q != 4'hF) begin
            samp_q <= samp_q + 4'h1;
         end
         calib_done_o <= (samp_q >= calib_samples_i);
      end
   end
endmodule

// File: tb/motor_control_sequencer_test.sv
`timescale 1ns/1ps
module motor_control_sequencer_test
   import motor_seq_pkg::*;
;
   logic clk = 1'b0, rst_n = 1'b0, fault = 1'b0, start = 1'b0, stop = 1'b0, clr = 1'b0;
   logic signed [15:0] speed_ref = 16'sh0000, thr = 16'sh0000, vq = 16'sh0000;
   logic [7:0] limit = 8'h00, awaddr = 8'h00, araddr = 8'h00;
   logic [3:0] calib_n = 4'h4, wstrb = 4'h0;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1, halted_q = 1'b1;
   logic adc_start, cl_act, loop_en, pwm_en, halted, sens_rst, soft_stop, cur_start;
   logic awready, wready, bvalid, arready, rvalid, midmatch, foc_done, calib_done;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, d;
   int err_count = 0, num_checks = 0, cycles = 0, halt_rises = 0;

   motor_control_sequencer dut (
      .core_clk_i(clk), .nrst_i(rst_n), .fault_i(fault), .start_motor_i(start), .stop_motor_i(stop),
      .fault_release_i(clr), .calib_done_i(calib_done), .pwm_midmatch_i(midmatch), .foc_done_i(foc_done),
      .speed_ref_i(speed_ref), .closed_loop_threshold_speed_i(thr), .q_axis_voltage_i(vq), .restart_limit_i(limit),
      .adc_start_o(adc_start), .closed_loop_active_o(cl_act), .current_loop_enable_o(loop_en),
      .pwm_enable_o(pwm_en), .motor_halted_o(halted), .sensor_reset_o(sens_rst), .soft_stop_o(soft_stop),
      .current_startup_o(cur_start), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   motor_far_side_model far (
      .core_clk_i(clk), .nrst_i(rst_n), .adc_start_i(adc_start), .loop_enable_i(loop_en),
      .sensor_reset_i(sens_rst), .calib_samples_i(calib_n), .midmatch_o(midmatch), .foc_done_o(foc_done),
      .calib_done_o(calib_done)
   );

   always #4 clk = ~clk;

   always @(posedge clk) begin
      halted_q <= halted;
      if (halted === 1'b1 && halted_q === 1'b0) begin
         halt_rises++;
      end
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_count++;
         stop_test();
      end
   end

   task stop_test();
      $display("Checks %0d, errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic pulse(input bit sel);
      if (sel) begin
         start <= 1'b1;
      end else begin
         clr <= 1'b1;
      end
      @(posedge clk);
      start <= 1'b0;
      clr <= 1'b0;
      @(posedge clk);
   endtask

   // Address and data are released separately, each at its own handshake
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
      bit aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      awaddr <= a;
      wdata <= v;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (awvalid && awready === 1'b1) begin
            awvalid <= 1'b0;
            aw_ok = 1'b1;
         end
         if (wvalid && wready === 1'b1) begin
            wvalid <= 1'b0;
            w_ok = 1'b1;
         end
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      chk(bresp, er);
   endtask

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      v = rdata;
      chk(rresp, er);
   endtask

   initial begin
      limit <= 8'h02;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk(halted, 1);
      chk(pwm_en, 0);
      axi_rd(CONFIG_ADDR, d, RESP_OKAY);
      chk(d, 0);
      axi_rd(LOCK_LEVEL_ADDR, d, RESP_OKAY);
      chk(d, {16'h0000, LOCK_LEVEL_RESET});
      axi_rd(8'h10, d, RESP_SLVERR);
      chk(d, 0);
      axi_wr(8'h10, 32'h0000_000F, RESP_SLVERR);
      axi_wr(STATUS_ADDR, 32'h0000_0006, RESP_OKAY);
      axi_rd(STATUS_ADDR, d, RESP_OKAY);
      chk(d[2:0], 0);
      axi_rd(LIMITS_ADDR, d, RESP_OKAY);
      chk(d, 2);
      speed_ref <= 16'sh0064;
      thr <= 16'sh0032;
      axi_wr(CONFIG_ADDR, 32'h0000_0002, RESP_OKAY);
      start <= 1'b1;
      ticks(2);
      chk(sens_rst, 1);
      while (sens_rst !== 1'b0) @(posedge clk);
      chk(halted, 1);
      while (pwm_en !== 1'b1) @(posedge clk);
      chk(loop_en, 1);
      axi_rd(STATUS_ADDR, d, RESP_OKAY);
      chk(d[2:0], 3);
      chk(cl_act, 1);
      thr <= 16'sh00C8;
      ticks(3);
      chk(cl_act, 0);
      thr <= 16'sh0064;
      ticks(3);
      chk(cl_act, 1);
      stop <= 1'b1;
      ticks(2);
      chk(pwm_en, 0);
      stop <= 1'b0;
      ticks(10);
      axi_rd(STATUS_ADDR, d, RESP_OKAY);
      chk(d[2:0], 0);
      start <= 1'b0;
      calib_n <= 4'h8;
      axi_wr(CONFIG_ADDR, 32'h0000_0008, RESP_OKAY);
      ticks(2);
      chk(cur_start, 0);
      pulse(1'b1);
      while (pwm_en !== 1'b1) @(posedge clk);
      stop <= 1'b1;
      ticks(3);
      chk(soft_stop, 1);
      chk(pwm_en, 1);
      speed_ref <= 16'sh0000;
      ticks(3);
      chk(soft_stop, 0);
      chk(pwm_en, 0);
      stop <= 1'b0;
      axi_wr(CONFIG_ADDR, 32'h0000_0005, RESP_OKAY);
      axi_wr(LOCK_LEVEL_ADDR, 32'h0000_1000, RESP_OKAY);
      ticks(2);
      chk(cur_start, 1);
      vq <= 16'sh2000;
      halt_rises = 0;
      pulse(1'b1);
      do axi_rd(STATUS_ADDR, d, RESP_OKAY); while (d[2:0] !== 3'h6);
      chk(d[15:8], 2);
      chk(d[5], 1);
      chk(halt_rises, 3);
      vq <= 16'sh0000;
      fault <= 1'b1;
      pulse(1'b0);
      pulse(1'b1);
      fault <= 1'b0;
      ticks(3);
      axi_rd(STATUS_ADDR, d, RESP_OKAY);
      chk(d[2:0], 6);
      pulse(1'b0);
      axi_rd(STATUS_ADDR, d, RESP_OKAY);
      chk(d[2:0], 0);
      pulse(1'b1);
      while (pwm_en !== 1'b1) @(posedge clk);
      fault <= 1'b1;
      ticks(2);
      chk(halted, 1);
      fault <= 1'b0;
      stop_test();
   end
endmodule
